// File: hdl/apm_alarm_priority_manager.sv
// Purpose: Alarm supervisor: ranks faults, drives lamp, display and output
// Assumes: Fault inputs are asynchronous; keys and host commands are synchronous
// Notes: One clear action removes only the top pending alarm
// Contract
// - Any non-fan alarm switches the main output off; the checksum alarms here leave the output as it is.
// - A new alarm lights the lamp and blinks its code.
// - With several pending, only the top one is shown.
// - Fixed precedence from line failure down to current loop.
// - Over-voltage and over-current always latch output off; some selectable.
// - Only fan, foldback, shutdown and under-voltage are maskable.
// - Checksum alarm only at boot or recall, outside the ranking.
// - Recall checksum failure keeps settings and pushes an error entry.
// - Boot checksum alarm clears only by soft reset or power cycle.
// - Recall checksum alarm clears after the panel timeout.
// - Holding adjust three seconds clears an alarm.
// - Each clear removes only the top pending alarm.
// - A manual clear shows the cleared message for a while.
// - A cleared alarm re-raises at once if its cause persists.
// - Self-clearing alarms drop when the cause goes away.
// - Lamp stays lit after a self-clearing alarm drops.
// - Mask bit one enables; foldback, shutdown, under-voltage at 8, 9, 10.
// - Latch bit set keeps output off; line 0, temperature 1, foldback 8.
// - Turning the output on after auto-clear dims the lamp.
`timescale 1ns/10ps
module apm_alarm_priority_manager
  import apm_pkg::*;
#(
  parameter int HOLD_CYCLES = APM_HOLD_CYCLES,
  parameter int MSG_CYCLES = APM_MSG_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire apm_fault_s faults,
  input wire logic adjust_pressed,
  input wire logic soft_reset_key,
  input wire logic host_clear,
  input wire logic output_on_req,
  input wire logic output_off_req,
  input wire logic [15:0] alarm_mask,
  input wire logic [15:0] alarm_latch,
  input wire logic [31:0] panel_timeout_cycles,
  output apm_panel_s panel,
  output logic [APM_NUM_ALARMS-1:0] alarm_pending
);

  // ----------------------------------------------------------------------
  // Reset release and input synchronisers
  // ----------------------------------------------------------------------
  logic rst_meta_reg, rst_sync_n;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_n <= rst_meta_reg;
    end
  end

  apm_fault_s flt_meta_reg, flt_sync_reg;
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      flt_meta_reg <= '0;
      flt_sync_reg <= '0;
    end else begin
      flt_meta_reg <= faults;
      flt_sync_reg <= flt_meta_reg;
    end
  end

  // ----------------------------------------------------------------------
  // Masking and latch selection
  // ----------------------------------------------------------------------
  logic [APM_NUM_ALARMS-1:0] enabled, latching, live;
  always_comb begin
    enabled = '1;
    enabled[APM_IDX_FAN] = alarm_mask[APM_MASK_FAN_BIT];
    enabled[APM_IDX_FOLD] = alarm_mask[APM_MASK_FOLD_BIT];
    enabled[APM_IDX_SHDN] = alarm_mask[APM_MASK_SHDN_BIT];
    enabled[APM_IDX_UVOLT] = alarm_mask[APM_MASK_UVOLT_BIT];
    latching = '0;
    latching[APM_IDX_OVOLT] = 1'b1;
    latching[APM_IDX_OCURR] = 1'b1;
    latching[APM_IDX_LINE] = alarm_latch[APM_LATCH_LINE_BIT];
    latching[APM_IDX_OTEMP] = alarm_latch[APM_LATCH_OTEMP_BIT];
    latching[APM_IDX_FOLD] = alarm_latch[APM_LATCH_FOLD_BIT];
    live = flt_sync_reg.cond & enabled;
  end

  // Lowest set index is the highest precedence
  function automatic logic [3:0] apm_top(input logic [APM_NUM_ALARMS-1:0] v);
    logic [3:0] r;
    r = APM_CODE_NONE;
    for (int i = APM_NUM_ALARMS - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction

  // Self-clearing alarms drop on their own; the others need a clear
  localparam logic [APM_NUM_ALARMS-1:0] AUTO_CLR =
    (10'h1 << APM_IDX_FAN) | (10'h1 << APM_IDX_ILOCK) | (10'h1 << APM_IDX_SHDN) |
    (10'h1 << APM_IDX_UVOLT);

  // ----------------------------------------------------------------------
  // State update
  // ----------------------------------------------------------------------
  apm_state_s st_reg, st_next;
  logic [3:0] top_idx;
  logic clear_act, new_alarm, restore_out;
  // Pre-alarm output state remembered for restore after a clear
  logic out_before_reg;
  logic [APM_NUM_ALARMS-1:0] rise;

  always_comb begin
    st_next = st_reg;
    st_next.err_push = 1'b0;
    top_idx = apm_top(st_reg.pend);
    restore_out = 1'b0;
    // Long press: count while held, one pulse at the target
    if (!adjust_pressed) begin
      st_next.hold_cnt = '0;
      st_next.hold_done = 1'b0;
    end else if (!st_reg.hold_done) begin
      st_next.hold_cnt = st_reg.hold_cnt + 32'h1;
    end
    clear_act = (adjust_pressed && !st_reg.hold_done &&
                 st_reg.hold_cnt == 32'(HOLD_CYCLES - 1)) || host_clear;
    if (clear_act && adjust_pressed) begin
      st_next.hold_done = 1'b1;
    end
    // Clear the top alarm only
    if (clear_act && top_idx != APM_CODE_NONE) begin
      st_next.pend[top_idx] = 1'b0;
      st_next.lamp = |(st_reg.pend & ~(10'h1 << top_idx));
      st_next.msg_cnt = 32'(MSG_CYCLES);
      restore_out = !latching[top_idx] && !(|(st_reg.pend & ~(10'h1 << top_idx) &
                    ~AUTO_CLR & ~(10'h1 << APM_IDX_FAN)));
    end else if (st_reg.msg_cnt != '0) begin
      st_next.msg_cnt = st_reg.msg_cnt - 32'h1;
    end
    st_next.pend = (st_next.pend & ~(AUTO_CLR & ~live)) | live;
    rise = live & ~st_reg.pend;
    new_alarm = |rise;
    if (new_alarm) begin
      st_next.lamp = 1'b1;
    end
    // Checksum alarms sit outside the ranking
    if (flt_sync_reg.boot_csum_fail) begin
      st_next.boot_csum = 1'b1;
    end else if (soft_reset_key) begin
      st_next.boot_csum = 1'b0;
    end
    if (flt_sync_reg.recall_csum_fail && !st_reg.recall_csum) begin
      st_next.recall_csum = 1'b1;
      st_next.err_push = 1'b1;
      st_next.tmo_cnt = panel_timeout_cycles;
      st_next.lamp = 1'b1;
    end else if (st_reg.recall_csum) begin
      if (st_reg.tmo_cnt <= 32'h1) begin
        st_next.recall_csum = 1'b0;
      end else begin
        st_next.tmo_cnt = st_reg.tmo_cnt - 32'h1;
      end
    end
    // Main output
    if (|(st_next.pend & ~(10'h1 << APM_IDX_FAN))) begin
      st_next.out_on = 1'b0;
    end else if (output_off_req) begin
      st_next.out_on = 1'b0;
    end else if (output_on_req) begin
      st_next.out_on = 1'b1;
      if (st_next.pend == '0) begin
        st_next.lamp = 1'b0;
      end
    end else if (restore_out) begin
      // Restore sits below the alarm check so a re-raised cause keeps it off
      st_next.out_on = out_before_reg;
    end
  end

  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      st_reg <= '0;
      out_before_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      if (st_reg.pend == '0) begin
        out_before_reg <= st_reg.out_on;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Panel outputs
  // ----------------------------------------------------------------------
  always_comb begin
    panel.lamp = st_reg.lamp | st_reg.boot_csum | st_reg.recall_csum;
    panel.out_on = st_reg.out_on;
    panel.err_push = st_reg.err_push;
    panel.blink = 1'b0;
    panel.code = APM_CODE_NONE;
    if (st_reg.boot_csum || st_reg.recall_csum) begin
      panel.code = APM_CODE_CHECKSUM;
      panel.blink = 1'b1;
    end else if (apm_top(st_reg.pend) != APM_CODE_NONE) begin
      panel.code = apm_top(st_reg.pend);
      panel.blink = 1'b1;
    end else if (st_reg.msg_cnt != '0) begin
      panel.code = APM_CODE_CLEARED;
    end
  end
  assign alarm_pending = st_reg.pend;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  a_out_off: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    |(st_reg.pend & ~(10'h1 << APM_IDX_FAN)) |-> !panel.out_on)
    else $error("output on during non-fan alarm");
  a_lamp_new: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    (|(live & ~st_reg.pend)) |=> panel.lamp && panel.blink)
    else $error("new alarm did not light lamp");
  a_top_shown: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    !st_reg.boot_csum && !st_reg.recall_csum && st_reg.pend != '0 |->
    panel.code == apm_top(st_reg.pend))
    else $error("displayed code is not top alarm");
  a_mask_block: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    !alarm_mask[APM_MASK_UVOLT_BIT] && !st_reg.pend[APM_IDX_UVOLT] |=>
    !st_reg.pend[APM_IDX_UVOLT] || $past(alarm_mask[APM_MASK_UVOLT_BIT]))
    else $error("masked alarm became pending");
  a_clr_one: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    clear_act && top_idx != APM_CODE_NONE |=>
    ($past(st_reg.pend) & ~st_reg.pend & ~(10'h1 << $past(top_idx)) & ~AUTO_CLR) == '0)
    else $error("clear removed too many alarms");
  a_err_push: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    panel.err_push |-> st_reg.recall_csum)
    else $error("error push without recall checksum");
  a_boot_hold: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    st_reg.boot_csum && !soft_reset_key |=> st_reg.boot_csum)
    else $error("boot checksum cleared without soft reset");
  a_ovp_latch: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    clear_act && top_idx == 4'(APM_IDX_OVOLT) |-> !restore_out)
    else $error("over-voltage clear restored output");

endmodule

// File: hdl/apm_pkg.sv
// Purpose: Shared constants and types for the alarm priority manager
// Assumes: 50 MHz core clock
// Notes: Alarm index order is the display precedence order, index 0 highest
package apm_pkg;

  // ----------------------------------------------------------------------
  // Alarm indices, highest precedence first
  // ----------------------------------------------------------------------
  localparam int APM_NUM_ALARMS = 10;
  localparam int APM_IDX_LINE = 0;
  localparam int APM_IDX_OTEMP = 1;
  localparam int APM_IDX_FAN = 2;
  localparam int APM_IDX_ILOCK = 3;
  localparam int APM_IDX_OVOLT = 4;
  localparam int APM_IDX_OCURR = 5;
  localparam int APM_IDX_FOLD = 6;
  localparam int APM_IDX_SHDN = 7;
  localparam int APM_IDX_UVOLT = 8;
  localparam int APM_IDX_LOOP = 9;

  // ----------------------------------------------------------------------
  // Mask and latch word bit positions
  // ----------------------------------------------------------------------
  localparam int APM_MASK_FAN_BIT = 3;
  localparam int APM_MASK_FOLD_BIT = 8;
  localparam int APM_MASK_SHDN_BIT = 9;
  localparam int APM_MASK_UVOLT_BIT = 10;
  localparam int APM_LATCH_LINE_BIT = 0;
  localparam int APM_LATCH_OTEMP_BIT = 1;
  localparam int APM_LATCH_FOLD_BIT = 8;

  // ----------------------------------------------------------------------
  // Display codes
  // ----------------------------------------------------------------------
  localparam logic [3:0] APM_CODE_NONE = 4'hF;
  localparam logic [3:0] APM_CODE_CHECKSUM = 4'hA;
  localparam logic [3:0] APM_CODE_CLEARED = 4'hB;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int APM_CLK_HZ = 50_000_000;
  localparam int APM_HOLD_S = 3;
  localparam int APM_HOLD_CYCLES = APM_HOLD_S * APM_CLK_HZ;
  localparam int APM_MSG_S = 2;
  localparam int APM_MSG_CYCLES = APM_MSG_S * APM_CLK_HZ;
  localparam int APM_CNT_W = 32;

  typedef struct packed {
    logic [APM_NUM_ALARMS-1:0] cond;
    logic boot_csum_fail;
    logic recall_csum_fail;
  } apm_fault_s;

  typedef struct packed {
    logic lamp;
    logic blink;
    logic [3:0] code;
    logic out_on;
    logic err_push;
  } apm_panel_s;

  typedef struct packed {
    logic [APM_NUM_ALARMS-1:0] pend;
    logic boot_csum;
    logic recall_csum;
    logic out_on;
    logic lamp;
    logic [APM_CNT_W-1:0] hold_cnt;
    logic hold_done;
    logic [APM_CNT_W-1:0] msg_cnt;
    logic [APM_CNT_W-1:0] tmo_cnt;
    logic err_push;
  } apm_state_s;

endpackage

// File: testbench/apm_alarm_priority_manager_bench.sv
// Purpose: Self-checking bench for the alarm priority manager
// Assumes: Short hold and message counts; faults settle within 4 cycles
// Notes: Expected values come from the precedence order and bit positions
`timescale 1ns/10ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_count++; \
  $display("unexpected at %0t: got %0h expected %0h", $time, a, b); end end
module apm_alarm_priority_manager_bench;
  import apm_pkg::*;
  localparam int HOLD = 20;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  apm_fault_s faults = '0;
  logic [15:0] alarm_mask = 16'h0000;
  logic [15:0] alarm_latch = 16'h0000;
  logic [31:0] tmo = 32'h0000_0010;
  logic adjust_pressed, soft_reset_key, host_clear, output_on_req, output_off_req;
  apm_panel_s panel;
  logic [APM_NUM_ALARMS-1:0] alarm_pending;
  int err_count = 0;
  int checked = 0;
  int pushes = 0;
  logic [9:0] lat_c[6] = '{10'h001, 10'h001, 10'h002, 10'h010, 10'h020, 10'h040};
  logic [15:0] lat_l[6] = '{16'h0000, 16'h0001, 16'h0002, 16'h0000, 16'h0000, 16'h0100};
  logic lat_o[6] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
  logic [3:0] seq[6] = '{4'h1, 4'h4, 4'h5, 4'h6, 4'h9, APM_CODE_CLEARED};
  initial forever #10 core_clk = ~core_clk;
  always @(posedge core_clk) if (panel.err_push === 1'b1) pushes++;
  apm_panel_model i_panel (.core_clk(core_clk), .adjust_pressed(adjust_pressed),
    .soft_reset_key(soft_reset_key), .host_clear(host_clear),
    .output_on_req(output_on_req), .output_off_req(output_off_req));
  apm_alarm_priority_manager #(.HOLD_CYCLES(HOLD), .MSG_CYCLES(10)) i_dut (
    .core_clk(core_clk), .rst_n(rst_n), .faults(faults), .adjust_pressed(adjust_pressed),
    .soft_reset_key(soft_reset_key), .host_clear(host_clear), .output_on_req(output_on_req),
    .output_off_req(output_off_req), .alarm_mask(alarm_mask), .alarm_latch(alarm_latch),
    .panel_timeout_cycles(tmo), .panel(panel), .alarm_pending(alarm_pending));
  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task automatic summarize;
    if (err_count == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // Fault inputs pass a two-flop synchroniser, so allow four edges
  task automatic set_cond(input logic [9:0] c);
    faults.cond = c;
    cyc(4);
  endtask
  task automatic csum(input logic boot);
    int n;
    if (boot) faults.boot_csum_fail = 1'b1;
    else faults.recall_csum_fail = 1'b1;
    cyc(2);
    {faults.boot_csum_fail, faults.recall_csum_fail} = 2'b00;
    for (n = 0; n < 50 && panel.code !== APM_CODE_CHECKSUM; n++) cyc(1);
    if (n == 50) begin
      `CHK(panel.code, APM_CODE_CHECKSUM)
      summarize();
    end
  endtask
  initial begin
    repeat (20) @(posedge core_clk);
    #1 rst_n = 1'b1;
    cyc(4);
    `CHK({panel.lamp, panel.code, alarm_pending}, 15'h3C00)
    alarm_mask = 16'h0708;
    i_panel.pulse(1);
    set_cond(10'h004);
    `CHK({panel.out_on, panel.lamp, panel.blink, panel.code}, 7'h72)
    set_cond(10'h000);
    `CHK({alarm_pending, panel.lamp}, 11'h001)
    i_panel.pulse(1);
    cyc(1);
    `CHK(panel.lamp, 1'b0)
    alarm_mask = 16'h0000;
    set_cond(10'h1C4);
    `CHK({alarm_pending, panel.lamp}, 11'h000)
    set_cond(10'h030);
    `CHK(alarm_pending, 10'h030)
    alarm_mask = 16'h0708;
    set_cond(10'h3FF);
    `CHK({panel.out_on, panel.code, alarm_pending}, 15'h03FF)
    set_cond(10'h000);
    `CHK(alarm_pending, 10'h273)
    foreach (seq[i]) begin
      i_panel.pulse(0);
      cyc(1);
      `CHK(panel.code, seq[i])
    end
    foreach (lat_c[i]) begin
      alarm_latch = lat_l[i];
      cyc(12);
      i_panel.pulse(1);
      set_cond(lat_c[i]);
      `CHK(panel.out_on, 1'b0)
      set_cond(10'h000);
      i_panel.pulse(0);
      cyc(1);
      `CHK(panel.out_on, lat_o[i])
    end
    set_cond(10'h010);
    i_panel.pulse(0);
    cyc(4);
    `CHK(alarm_pending, 10'h010)
    set_cond(10'h000);
    i_panel.pulse(0);
    set_cond(10'h021);
    set_cond(10'h020);
    i_panel.hold(HOLD + 2);
    cyc(1);
    `CHK(alarm_pending, 10'h020)
    i_panel.hold(HOLD - 2);
    cyc(1);
    `CHK(alarm_pending, 10'h020)
    set_cond(10'h000);
    i_panel.hold(HOLD + 2);
    cyc(1);
    `CHK({alarm_pending, panel.code}, 14'h000B)
    cyc(12);
    tmo = 32'h0000_0040;
    csum(1'b0);
    cyc(1);
    `CHK({pushes, alarm_pending}, {32'd1, 10'h000})
    cyc(47);
    `CHK(panel.code, APM_CODE_CHECKSUM)
    cyc(32);
    `CHK(panel.code == APM_CODE_CHECKSUM, 1'b0)
    csum(1'b1);
    i_panel.pulse(0);
    i_panel.hold(HOLD + 2);
    cyc(80);
    `CHK(panel.code, APM_CODE_CHECKSUM)
    i_panel.pulse(3);
    cyc(2);
    `CHK(panel.code == APM_CODE_CHECKSUM, 1'b0)
    summarize();
  end
endmodule

// File: testbench/apm_panel_model.sv
// Purpose: Front-panel keys and remote host facing the alarm manager
// Assumes: Requests change 1 ns after a core_clk rise
// Notes: Long press length is chosen by the caller; pulses last one cycle
`timescale 1ns/10ps
module apm_panel_model (
  input wire logic core_clk,
  output logic adjust_pressed,
  output logic soft_reset_key,
  output logic host_clear,
  output logic output_on_req,
  output logic output_off_req
);
  initial begin
    {adjust_pressed, soft_reset_key, host_clear, output_on_req, output_off_req} = 5'h00;
  end
  // ----------------------------------------------------------------------
  // Requests: 0 clear, 1 output on, 2 output off, 3 soft reset
  // ----------------------------------------------------------------------
  task automatic pulse(input int sel);
    @(posedge core_clk) #1;
    case (sel)
      0: host_clear = 1'b1;
      1: output_on_req = 1'b1;
      2: output_off_req = 1'b1;
      default: soft_reset_key = 1'b1;
    endcase
    @(posedge core_clk) #1;
    {soft_reset_key, host_clear, output_on_req, output_off_req} = 4'h0;
  endtask
  task automatic hold(input int n);
    @(posedge core_clk) #1;
    adjust_pressed = 1'b1;
    repeat (n) @(posedge core_clk);
    #1 adjust_pressed = 1'b0;
  endtask
endmodule
